// File: hdl/exec_consts.vh
// Constants for the instruction execution datapath
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH
// Register byte offsets
`define OFS_ACCUM 8'h00
`define OFS_STATUS 8'h04
`define OFS_COMMAND 8'h08
`define OFS_PC 8'h0C
`define OFS_STACK 8'h10
`define OFS_WATCHDOG 8'h14
`define OFS_DATA 8'h20
// Status bit positions
`define ST_CARRY 0
`define ST_AUX 1
`define ST_ZERO 2
`define ST_OVFL 3
`define ST_PWRDN 4
`define ST_TMOUT 5
`define ST_BUSY 8
`define ST_PRE_FIRST 9
`define ST_PRE_SECOND 10
// Command fields
`define CMD_OP_HI 4
`define CMD_OP_LO 0
`define CMD_BIT_HI 7
`define CMD_BIT_LO 5
`define CMD_ADDR_HI 10
`define CMD_ADDR_LO 8
`define CMD_IMM_HI 25
`define CMD_IMM_LO 16
// Operation codes
`define OP_NOP 5'h00
`define OP_ADD_CARRY_ACC 5'h01
`define OP_ADD_CARRY_MEM 5'h02
`define OP_ADD_ACC 5'h03
`define OP_ADD_IMM 5'h04
`define OP_ADD_MEM 5'h05
`define OP_AND_ACC 5'h06
`define OP_AND_IMM 5'h07
`define OP_AND_MEM 5'h08
`define OP_CALL 5'h09
`define OP_ZERO_BYTE 5'h0A
`define OP_ZERO_BIT 5'h0B
`define OP_WD_CLEAR 5'h0C
`define OP_WD_PRE_FIRST 5'h0D
`define OP_WD_PRE_SECOND 5'h0E
`define OP_INV_MEM 5'h0F
`define OP_INV_ACC 5'h10
`define OP_DEC_ADJ 5'h11
`define OP_DECR_MEM 5'h12
`define OP_DECR_ACC 5'h13
// Reset values
`define RST_BYTE 8'h00
`define RST_PC 10'h000
`define RST_FLAGS 6'h00
// Timing: one instruction cycle is four system clocks
`define CLKS_PER_CYCLE 4
`define BUSY_ONE 4'h3
`define BUSY_TWO 4'h7
`define BUSY_THREE 4'hB
// Decimal adjust figures
`define BCD_MAX 5'h09
`define BCD_FIX 5'h06
// Data memory: index 0 aliases the program counter low byte
`define PC_LOW_INDEX 3'h0
`endif

// File: hdl/watchdog_unit.v
// Watchdog counter with prescaler and restart control
module watchdog_unit (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Control
    input wire restart,
    // State
    output reg [7:0] watchdog_counter,
    output reg timeout_pulse
);
    reg [7:0] prescaler;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prescaler <= 8'h00;
            watchdog_counter <= 8'h00;
            timeout_pulse <= 1'b0;
        end
        else if (ce)
        begin
            timeout_pulse <= 1'b0;
            if (restart)
            begin
                prescaler <= 8'h00;
                watchdog_counter <= 8'h00;
            end
            else
            begin
                prescaler <= prescaler + 8'h01;
                if (prescaler == 8'hFF)
                begin
                    watchdog_counter <= watchdog_counter + 8'h01;
                    // Counter wraps; the expiry is reported once
                    if (watchdog_counter == 8'hFF)
                        timeout_pulse <= 1'b1;
                end
            end
        end
    end
endmodule // watchdog_unit

// File: hdl/exec_unit.v
// Instruction execution datapath with APB register access
// What this block does
// - add-with-carry to accumulator: acc+mem+carry, flags OV Z AC C
// - add-with-carry to memory: acc+mem+carry into byte, flags OV Z AC C
// - add memory to accumulator, no carry in, flags OV Z AC C
// - add immediate to accumulator, no carry in, flags OV Z AC C
// - add accumulator into memory byte, no carry in, flags OV Z AC C
// - AND memory into accumulator, only zero flag changes
// - AND immediate into accumulator, only zero flag changes
// - AND accumulator into memory byte, only zero flag changes
// - call pushes pc plus one, loads target, flags untouched
// - byte clear writes zero to memory, flags untouched
// - bit clear zeroes one selected bit, others and flags untouched
// - watchdog clear restarts counter and prescaler, clears both flags
// - preclear acts only when the partner preclear already ran
// - lone preclear only records itself, watchdog and flags kept
// - invert memory byte in place, only zero flag changes
// - inverted byte to accumulator, memory kept, only zero flag
// - decimal adjust low nibble adds six when above nine or aux
// - decimal adjust high nibble adds low carry, then six and sets carry when above nine or carry
// - decimal adjust writes memory only, only carry may change
// - decrement memory byte in place, only zero flag changes
// - decremented byte to accumulator, memory kept, only zero flag
// - writing pc low byte costs one extra instruction cycle
//
// Chosen here: the APB register port and the placing of the registers.
`include "exec_consts.vh"
module exec_unit (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Status
    output wire busy
);
    reg [7:0] accumulator_reg;
    reg carry_flag;
    reg aux_carry_flag;
    reg zero_flag;
    reg overflow_flag;
    reg powerdown_flag;
    reg timeout_flag;
    reg pre_first_seen;
    reg pre_second_seen;
    reg [9:0] pc;
    reg [9:0] stack_mem [0:3];
    reg [1:0] sp;
    reg [3:0] busy_count;
    reg [7:0] ram [1:7];
    wire [7:0] watchdog_counter;
    wire timeout_pulse;

    // APB decode
    wire setup = psel && !penable;
    wire access = psel && penable && ce;
    wire wr = access && pwrite;
    wire is_data = (paddr[7:5] == 3'h1) && (paddr[1:0] == 2'b00);
    wire [2:0] data_idx = paddr[4:2];
    wire mapped = is_data || paddr == `OFS_ACCUM || paddr == `OFS_STATUS ||
        paddr == `OFS_COMMAND || paddr == `OFS_PC ||
        paddr == `OFS_STACK || paddr == `OFS_WATCHDOG;
    assign pready = ce;
    assign pslverr = access && !mapped;
    assign busy = busy_count != 4'h0;

    // Command fields
    wire [4:0] op = pwdata[`CMD_OP_HI:`CMD_OP_LO];
    wire [2:0] bit_sel = pwdata[`CMD_BIT_HI:`CMD_BIT_LO];
    wire [2:0] mem_idx = pwdata[`CMD_ADDR_HI:`CMD_ADDR_LO];
    wire [9:0] imm = pwdata[`CMD_IMM_HI:`CMD_IMM_LO];
    // Commands arriving while busy are dropped, not queued
    wire issue = wr && paddr == `OFS_COMMAND && !busy;

    wire [7:0] mem_val = (mem_idx == `PC_LOW_INDEX) ? pc[7:0] : ram[mem_idx];

    // Shared adder
    reg [7:0] add_b;
    reg add_cin;
    reg [8:0] sum;
    reg [4:0] low_sum;
    reg add_ovf;
    // Decimal adjust
    reg [4:0] dlo;
    reg low_nibble_carry;
    reg [4:0] dhi;
    reg dcarry;
    // Execution results
    reg [7:0] next_result;
    reg to_acc;
    reg to_mem;
    reg upd_zero;
    reg upd_arith;
    reg upd_carry;
    reg next_carry;
    reg wd_restart;
    reg next_pre_first;
    reg next_pre_second;
    reg is_call;

    always @*
    begin
        add_b = mem_val;
        add_cin = 1'b0;
        if (op == `OP_ADD_IMM)
            add_b = imm[7:0];
        if (op == `OP_ADD_CARRY_ACC || op == `OP_ADD_CARRY_MEM)
            add_cin = carry_flag;
        sum = {1'b0, accumulator_reg} + {1'b0, add_b} + {8'h00, add_cin};
        low_sum = {1'b0, accumulator_reg[3:0]} + {1'b0, add_b[3:0]} +
            {4'h0, add_cin};
        add_ovf = (accumulator_reg[7] == add_b[7]) &&
            (sum[7] != accumulator_reg[7]);

        dlo = {1'b0, accumulator_reg[3:0]};
        if (dlo > `BCD_MAX || aux_carry_flag)
            dlo = dlo + `BCD_FIX;
        low_nibble_carry = dlo[4];
        dhi = {1'b0, accumulator_reg[7:4]} + {4'h0, low_nibble_carry};
        dcarry = carry_flag || dhi > `BCD_MAX;
        if (dcarry)
            dhi = dhi + `BCD_FIX;
        next_result = sum[7:0];
        to_acc = 1'b0;
        to_mem = 1'b0;
        upd_zero = 1'b0;
        upd_arith = 1'b0;
        upd_carry = 1'b0;
        next_carry = sum[8];
        wd_restart = 1'b0;
        next_pre_first = pre_first_seen;
        next_pre_second = pre_second_seen;
        is_call = 1'b0;
        case (op)
            `OP_ADD_CARRY_ACC, `OP_ADD_ACC, `OP_ADD_IMM:
            begin
                to_acc = 1'b1;
                upd_arith = 1'b1;
            end
            `OP_ADD_CARRY_MEM, `OP_ADD_MEM:
            begin
                to_mem = 1'b1;
                upd_arith = 1'b1;
            end
            `OP_AND_ACC:
            begin
                next_result = accumulator_reg & mem_val;
                to_acc = 1'b1;
                upd_zero = 1'b1;
            end
            `OP_AND_IMM:
            begin
                next_result = accumulator_reg & imm[7:0];
                to_acc = 1'b1;
                upd_zero = 1'b1;
            end
            `OP_AND_MEM:
            begin
                next_result = accumulator_reg & mem_val;
                to_mem = 1'b1;
                upd_zero = 1'b1;
            end
            `OP_CALL: is_call = 1'b1;
            `OP_ZERO_BYTE:
            begin
                next_result = 8'h00;
                to_mem = 1'b1;
            end
            `OP_ZERO_BIT:
            begin
                next_result = mem_val & ~(8'h01 << bit_sel);
                to_mem = 1'b1;
            end
            `OP_WD_CLEAR:
            begin
                wd_restart = 1'b1;
                next_pre_first = 1'b0;
                next_pre_second = 1'b0;
            end
            `OP_WD_PRE_FIRST, `OP_WD_PRE_SECOND:
            begin
                if (op == `OP_WD_PRE_FIRST ? pre_second_seen : pre_first_seen)
                begin
                    wd_restart = 1'b1;
                    next_pre_first = 1'b0;
                    next_pre_second = 1'b0;
                end
                else if (op == `OP_WD_PRE_FIRST)
                    next_pre_first = 1'b1;
                else
                    next_pre_second = 1'b1;
            end
            `OP_INV_MEM:
            begin
                next_result = ~mem_val;
                to_mem = 1'b1;
                upd_zero = 1'b1;
            end
            `OP_INV_ACC:
            begin
                next_result = ~mem_val;
                to_acc = 1'b1;
                upd_zero = 1'b1;
            end
            `OP_DEC_ADJ:
            begin
                next_result = {dhi[3:0], dlo[3:0]};
                to_mem = 1'b1;
                upd_carry = 1'b1;
                next_carry = dcarry;
            end
            `OP_DECR_MEM:
            begin
                next_result = mem_val - 8'h01;
                to_mem = 1'b1;
                upd_zero = 1'b1;
            end
            `OP_DECR_ACC:
            begin
                next_result = mem_val - 8'h01;
                to_acc = 1'b1;
                upd_zero = 1'b1;
            end
            default: next_result = sum[7:0];
        endcase
    end
    wire pcl_write = issue && to_mem && mem_idx == `PC_LOW_INDEX;
    wire [9:0] pc_inc = pc + 10'h001;
    watchdog_unit u_watchdog (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .restart(issue && wd_restart),
        .watchdog_counter(watchdog_counter),
        .timeout_pulse(timeout_pulse)
    );
    // Accumulator, flags, program counter, stack, timing
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            accumulator_reg <= `RST_BYTE;
            {timeout_flag, powerdown_flag, overflow_flag, zero_flag,
                aux_carry_flag, carry_flag} <= `RST_FLAGS;
            pre_first_seen <= 1'b0;
            pre_second_seen <= 1'b0;
            pc <= `RST_PC;
            sp <= 2'h0;
            stack_mem[0] <= `RST_PC;
            stack_mem[1] <= `RST_PC;
            stack_mem[2] <= `RST_PC;
            stack_mem[3] <= `RST_PC;
            busy_count <= 4'h0;
        end
        else if (ce)
        begin
            if (busy)
                busy_count <= busy_count - 4'h1;
            if (wr && paddr == `OFS_ACCUM)
                accumulator_reg <= pwdata[7:0];
            // Flag bits sit side by side, carry lowest
            if (wr && paddr == `OFS_STATUS)
                {timeout_flag, powerdown_flag, overflow_flag,
                    zero_flag, aux_carry_flag, carry_flag} <=
                    pwdata[`ST_TMOUT:`ST_CARRY];
            if (wr && paddr == `OFS_PC)
                pc <= pwdata[9:0];
            if (issue)
            begin
                busy_count <= `BUSY_ONE;
                pc <= pc_inc;
                pre_first_seen <= next_pre_first;
                pre_second_seen <= next_pre_second;
                if (to_acc)
                    accumulator_reg <= next_result;
                if (upd_zero || upd_arith)
                    zero_flag <= next_result == 8'h00;
                if (upd_arith)
                begin
                    overflow_flag <= add_ovf;
                    aux_carry_flag <= low_sum[4];
                end
                if (upd_arith || upd_carry)
                    carry_flag <= next_carry;
                if (wd_restart)
                begin
                    timeout_flag <= 1'b0;
                    powerdown_flag <= 1'b0;
                end
                if (is_call)
                begin
                    stack_mem[sp] <= pc_inc;
                    sp <= sp + 2'h1;
                    pc <= imm;
                    busy_count <= `BUSY_TWO;
                end
                if (pcl_write)
                begin
                    pc <= {pc[9:8], next_result};
                    busy_count <= `BUSY_TWO;
                end
            end
            // Expiry wins over any clear in the same cycle
            if (timeout_pulse)
                timeout_flag <= 1'b1;
        end
    end

    // Data memory, one entry per generate pass
    genvar i;
    generate
        for (i = 1; i < 8; i = i + 1)
        begin : g_ram
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ram[i] <= `RST_BYTE;
                else if (ce)
                begin
                    if (issue && to_mem && mem_idx == i)
                        ram[i] <= next_result;
                    else if (wr && is_data && data_idx == i)
                        ram[i] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // Read data captured in the setup phase, stable through access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (ce && setup)
        begin
            prdata <= 32'h0000_0000;
            if (is_data)
                prdata[7:0] <= (data_idx == `PC_LOW_INDEX) ? pc[7:0] :
                    ram[data_idx];
            else
                case (paddr)
                    `OFS_ACCUM:
                        prdata[7:0] <= accumulator_reg;
                    `OFS_STATUS:
                        prdata[10:0] <= {pre_second_seen, pre_first_seen,
                            busy, 2'b00, timeout_flag, powerdown_flag,
                            overflow_flag, zero_flag, aux_carry_flag,
                            carry_flag};
                    `OFS_PC:
                        prdata[9:0] <= pc;
                    `OFS_STACK:
                        prdata[17:0] <= {sp, 6'h00, stack_mem[sp - 2'h1]};
                    `OFS_WATCHDOG:
                        prdata[7:0] <= watchdog_counter;
                    default:
                        prdata <= 32'h0000_0000;
                endcase
        end
    end
endmodule // exec_unit

// File: test/apb_host.sv
// APB master standing in for the instruction sequencer
module apb_host (
    // Clock
    input wire logic pclk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // Answer
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] rdata;
    logic rerr;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep looking valid
        paddr <= ~addr;
        pwdata <= ~data;
    endtask
endmodule // apb_host

// File: test/exec_unit_properties.sv
// Timing and bus checks on the execution datapath ports
`include "exec_consts.vh"
module exec_unit_properties (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    // Status
    input wire busy
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire access = psel && penable;
    wire mapped = paddr[1:0] == 2'b00 &&
        (paddr <= 8'h14 || (paddr >= 8'h20 && paddr <= 8'h3C));
    wire [4:0] op = pwdata[4:0];
    wire cmd_take = access && pwrite && ce && !busy &&
        paddr == `OFS_COMMAND;
    wire mem_op = op == `OP_ADD_CARRY_MEM || op == `OP_ADD_MEM ||
        op == `OP_AND_MEM || op == `OP_ZERO_BYTE || op == `OP_ZERO_BIT ||
        op == `OP_INV_MEM || op == `OP_DEC_ADJ || op == `OP_DECR_MEM;
    wire long_op = op == `OP_CALL || (mem_op && pwdata[10:8] == 3'h0);

    sequence run_short;
        busy [*3] ##1 !busy;
    endsequence
    sequence run_long;
        busy [*7] ##1 !busy;
    endsequence

    AST_SHORT_RUN: assert property (cmd_take && !long_op |=> run_short)
        else $error("busy span wrong for plain instruction");
    AST_LONG_RUN: assert property (cmd_take && long_op |=> run_long)
        else $error("busy span wrong for pc loading instruction");
    AST_BUSY_CAUSE: assert property ($rose(busy) |->
        $past(access && pwrite && paddr == `OFS_COMMAND))
        else $error("busy rose without a command write");
    AST_UNMAPPED_ERR: assert property (access && !mapped |-> pslverr)
        else $error("no error on unmapped address");
    AST_MAPPED_OK: assert property (access && mapped |-> !pslverr)
        else $error("error on mapped address");
    AST_UNMAPPED_ZERO: assert property
        (access && !pwrite && !mapped |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    AST_COMMAND_ZERO: assert property
        (access && !pwrite && paddr == `OFS_COMMAND |-> prdata == 32'h0)
        else $error("command register read not zero");
    AST_ACCUM_UPPER: assert property
        (access && !pwrite && paddr == `OFS_ACCUM |-> prdata[31:8] == 24'h0)
        else $error("accumulator upper bits not zero");
    AST_READY_CE: assert property (pready == ce)
        else $error("ready does not follow enable");
endmodule // exec_unit_properties

bind exec_unit exec_unit_properties chk (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .busy(busy));

// File: test/mcu_instruction_semantics_a_to_d_bench.sv
// Self-checking bench for the instruction execution datapath
`include "exec_consts.vh"
module mcu_instruction_semantics_a_to_d_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] mem_one = `OFS_DATA + 8'h04;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int miscompares = 0;
    int comparisons = 0;
    logic [7:0] wd_seen;

    always #5 pclk = ~pclk;

    exec_unit dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .busy(busy));
    apb_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic expect_reg(input string what, input logic [7:0] addr,
                              input logic [31:0] mask, input logic [31:0] exp);
        host.xfer(1'b0, addr, 32'h0);
        check(what, exp, host.rdata & mask);
    endtask

    // Commands written while busy are dropped, so wait it out
    task automatic cmd(input logic [31:0] word);
        host.xfer(1'b1, `OFS_COMMAND, word);
        @(posedge pclk);
        while (busy !== 1'b0)
            @(posedge pclk);
    endtask

    // in: accum, byte, flags, immediate or bit; out: accum, byte, flags
    task automatic run_case(input logic [4:0] op, input logic [31:0] in,
                            input logic [23:0] out);
        host.xfer(1'b1, `OFS_ACCUM, {24'h0, in[31:24]});
        host.xfer(1'b1, mem_one, {24'h0, in[23:16]});
        host.xfer(1'b1, `OFS_STATUS, {24'h0, in[15:8]});
        cmd({8'h00, in[7:0], 5'h00, 3'h1, in[2:0], op});
        expect_reg("accum", `OFS_ACCUM, 32'hFF, {24'h0, out[23:16]});
        expect_reg("byte", mem_one, 32'hFF, {24'h0, out[15:8]});
        expect_reg("flags", `OFS_STATUS, 32'h3F, {24'h0, out[7:0]});
    endtask

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        expect_reg("accum", `OFS_ACCUM, 32'hFFFFFFFF, 32'h0);
        expect_reg("status", `OFS_STATUS, 32'hFFFFFFFF, 32'h0);
        expect_reg("pc", `OFS_PC, 32'hFFFFFFFF, 32'h0);
        expect_reg("stack", `OFS_STACK, 32'hFFFFFFFF, 32'h0);
        expect_reg("command", `OFS_COMMAND, 32'hFFFFFFFF, 32'h0);
        $display("test reset_values done");
        run_case(`OP_ADD_CARRY_ACC, 32'h7F000100, 24'h80000A);
        run_case(`OP_ADD_CARRY_MEM, 32'hFF000100, 24'hFF0007);
        run_case(`OP_ADD_ACC, 32'h88880000, 24'h10880B);
        run_case(`OP_ADD_IMM, 32'h010001FF, 24'h000007);
        run_case(`OP_ADD_MEM, 32'h0F013000, 24'h0F1032);
        run_case(`OP_AND_ACC, 32'hF00F0B00, 24'h000F0F);
        run_case(`OP_AND_IMM, 32'h3C00040F, 24'h0C0000);
        run_case(`OP_AND_MEM, 32'h55FF0000, 24'h555500);
        run_case(`OP_ZERO_BYTE, 32'h00A52F00, 24'h00002F);
        run_case(`OP_ZERO_BIT, 32'h00FF0003, 24'h00F700);
        run_case(`OP_INV_MEM, 32'h00FF0000, 24'h000004);
        run_case(`OP_INV_ACC, 32'h000F0400, 24'hF00F00);
        run_case(`OP_DEC_ADJ, 32'h9A000400, 24'h9A0005);
        run_case(`OP_DEC_ADJ, 32'h12000200, 24'h121802);
        run_case(`OP_DECR_MEM, 32'h00010000, 24'h000004);
        run_case(`OP_DECR_ACC, 32'h00000400, 24'hFF0000);
        $display("test datapath done");
        host.xfer(1'b1, `OFS_PC, 32'h005);
        host.xfer(1'b1, `OFS_STATUS, 32'h15);
        cmd({6'h00, 10'h123, 11'h000, `OP_CALL});
        expect_reg("pc", `OFS_PC, 32'h3FF, 32'h123);
        expect_reg("stack", `OFS_STACK, 32'h303FF, 32'h10006);
        expect_reg("flags", `OFS_STATUS, 32'h3F, 32'h15);
        host.xfer(1'b1, `OFS_PC, 32'h2F0);
        cmd({27'h0, `OP_ZERO_BYTE});
        expect_reg("pc", `OFS_PC, 32'h3FF, 32'h200);
        $display("test call_and_pc done");
        host.xfer(1'b1, `OFS_ACCUM, 32'h01);
        host.xfer(1'b1, `OFS_COMMAND, {16'h0001, 11'h0, `OP_ADD_IMM});
        cmd({16'h0001, 11'h0, `OP_ADD_IMM});
        expect_reg("accum", `OFS_ACCUM, 32'hFF, 32'h02);
        expect_reg("unmapped", 8'h18, 32'hFFFFFFFF, 32'h0);
        check("slverr", 32'h1, {31'h0, host.rerr});
        $display("test refusals done");
        // Let the watchdog count so its clearing shows
        repeat (600) @(posedge pclk);
        host.xfer(1'b1, `OFS_STATUS, 32'h30);
        cmd({27'h0, `OP_WD_PRE_FIRST});
        expect_reg("status", `OFS_STATUS, 32'h23F, 32'h230);
        host.xfer(1'b0, `OFS_WATCHDOG, 32'h0);
        check("wd_run", 32'h1, {31'h0, host.rdata[7:0] != 8'h00});
        cmd({27'h0, `OP_WD_PRE_SECOND});
        expect_reg("status", `OFS_STATUS, 32'h3F, 32'h00);
        expect_reg("wd", `OFS_WATCHDOG, 32'hFF, 32'h00);
        repeat (600) @(posedge pclk);
        host.xfer(1'b1, `OFS_STATUS, 32'h30);
        cmd({27'h0, `OP_WD_CLEAR});
        expect_reg("status", `OFS_STATUS, 32'h3F, 32'h00);
        expect_reg("wd", `OFS_WATCHDOG, 32'hFF, 32'h00);
        $display("test watchdog done");
        // Enable low must hold the watchdog where it stands
        host.xfer(1'b0, `OFS_WATCHDOG, 32'h0);
        wd_seen = host.rdata[7:0];
        ce <= 1'b0;
        repeat (600) @(posedge pclk);
        ce <= 1'b1;
        host.xfer(1'b0, `OFS_WATCHDOG, 32'h0);
        check("frozen", 32'h1, {31'h0, host.rdata[7:0] - wd_seen < 8'h02});
        $display("test clock_enable done");
        report_and_stop;
    end

    // Tests need about 24 us; about four times that before giving up
    initial
    begin
        #100us;
        miscompares++;
        report_and_stop;
    end
endmodule // mcu_instruction_semantics_a_to_d_bench
